// *** design/drive_control_word_decoder.sv ***
// drive command word decoder: state machine, mode bits, status and error code words
// assumes fieldbus process data and fault sources run on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.svh"

module drive_control_word_decoder
    import drive_ctl_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // command word write from received process data
    input  wire logic        cmdWrEn,
    input  wire logic [15:0] cmdWrData,
    // drive context
    input  wire logic [7:0]  opMode,
    input  wire logic        fwNewGen,
    input  wire logic        faultEvt,
    input  wire logic [7:0]  faultNum,
    input  wire logic        warnEvt,
    // object readback and decoded requests
    output logic [15:0]      cmdWordRd,
    output logic [15:0]      stateWord,
    output logic [15:0]      errCode,
    output var state_t       driveState,
    output var mode_req_t    modeReq,
    output logic             faultClear
);

    logic [15:0] cmdWord_ff;
    state_t      state_ff;
    state_t      nxt_state;
    cmd_t        cmd;
    logic [15:0] errCode_ff;
    logic [15:0] stateWord_ff;
    mode_req_t   modeReq_ff;
    logic        faultClear_ff;
    logic        rstBit_ff;
    logic        warn_ff;
    logic        badSeen_ff;
    logic        modeBad;
    logic        faultSrc;
    logic [7:0]  faultSel;

    // (RQ8) (RQ9) (RQ19) patterns in priority order
    function automatic cmd_t decode_cmd(input logic [15:0] w);
        if (w[`CW_FAULT_RESET]) begin
            decode_cmd = CMD_FAULT_RESET;
        end else if (!w[`CW_ENABLE_VOLTAGE]) begin
            decode_cmd = CMD_DIS_VOLTAGE;
        end else if (!w[`CW_QUICK_STOP]) begin
            decode_cmd = CMD_QUICK_STOP;
        end else if (!w[`CW_SWITCH_ON]) begin
            decode_cmd = CMD_SHUTDOWN;
        end else if (w[`CW_ENABLE_OP]) begin
            decode_cmd = CMD_ENABLE_OP;
        end else begin
            decode_cmd = CMD_DIS_OP;
        end
    endfunction : decode_cmd

    // (RQ12) fault number to error code
    function automatic logic [15:0] map_fault(input logic [7:0] num, input logic newGen);
        map_fault = {`ERR_NEW_BASE, num};
        if (!newGen) begin
            // (RQ16) first generation torque-off code
            if (num == `FLT_TORQUE_OFF) begin
                map_fault = `ERR_OLD_TORQUE_OFF;
            // (RQ13) (RQ14) (RQ15) first generation sync block
            end else if (num >= `FLT_SYNC_LOST && num <= `FLT_FOE && num != `FLT_COE_CFG) begin
                map_fault = {`ERR_NEW_BASE, num - `ERR_OLD_SYNC_OFS};
            end
        end
    endfunction : map_fault

    // (RQ18) state to status bits
    function automatic logic [15:0] encode_state(input state_t s, input logic w);
        logic [6:0] b;
        b = 7'h00;
        case (s)
            ST_NOT_READY:  b = 7'b0000000;
            ST_SW_ON_DIS:  b = 7'b1100000;
            ST_READY:      b = 7'b0110001;
            ST_SWITCHED:   b = 7'b0110011;
            ST_OP_ENABLED: b = 7'b0110111;
            ST_QS_ACTIVE:  b = 7'b0000111;
            ST_FLT_REACT:  b = 7'b0101111;
            ST_FAULT:      b = 7'b0101000;
            default:       b = 7'b0000000;
        endcase
        encode_state = {6'h00, (s != ST_NOT_READY), 1'b0, w, b};
        encode_state[`SW_VOLTAGE_EN] = (s == ST_READY) || (s == ST_SWITCHED)
                                       || (s == ST_OP_ENABLED) || (s == ST_QS_ACTIVE);
    endfunction : encode_state

    // (RQ10) decoded fresh each cycle
    assign cmd = decode_cmd(cmdWord_ff);

    // (RQ15) unsupported mode detection
    assign modeBad = !(opMode == `MODE_PP || opMode == `MODE_PV || opMode == `MODE_TQ
                       || opMode == `MODE_HM || opMode == `MODE_CSP
                       || opMode == `MODE_CSV || opMode == `MODE_CST);
    assign faultSrc = faultEvt || (modeBad && !badSeen_ff);
    assign faultSel = faultEvt ? faultNum : `FLT_BAD_MODE;

    // (RQ1) command object store; reserved bits kept as written
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmdWord_ff <= `CMD_WORD_RESET;
        end else if (clkEn && cmdWrEn) begin
            cmdWord_ff <= cmdWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            badSeen_ff <= 1'b0;
        end else if (clkEn) begin
            badSeen_ff <= modeBad;
        end
    end

    // (RQ2) transition selection
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_NOT_READY:  nxt_state = ST_SW_ON_DIS;
            ST_SW_ON_DIS: begin
                if (cmd == CMD_SHUTDOWN) begin
                    nxt_state = ST_READY;
                end
            end
            ST_READY: begin
                if (cmd == CMD_SWITCH_ON || cmd == CMD_DIS_OP || cmd == CMD_ENABLE_OP) begin
                    nxt_state = ST_SWITCHED;
                end else if (cmd == CMD_DIS_VOLTAGE || cmd == CMD_QUICK_STOP) begin
                    nxt_state = ST_SW_ON_DIS;
                end
            end
            ST_SWITCHED: begin
                if (cmd == CMD_ENABLE_OP) begin
                    nxt_state = ST_OP_ENABLED;
                end else if (cmd == CMD_SHUTDOWN) begin
                    nxt_state = ST_READY;
                end else if (cmd == CMD_DIS_VOLTAGE || cmd == CMD_QUICK_STOP) begin
                    nxt_state = ST_SW_ON_DIS;
                end
            end
            ST_OP_ENABLED: begin
                if (cmd == CMD_DIS_OP) begin
                    nxt_state = ST_SWITCHED;
                end else if (cmd == CMD_SHUTDOWN) begin
                    nxt_state = ST_READY;
                end else if (cmd == CMD_DIS_VOLTAGE) begin
                    nxt_state = ST_SW_ON_DIS;
                end else if (cmd == CMD_QUICK_STOP) begin
                    nxt_state = ST_QS_ACTIVE;
                end
            end
            // (RQ3) no ramp: leave quick stop next cycle
            ST_QS_ACTIVE: begin
                nxt_state = (cmd == CMD_ENABLE_OP) ? ST_OP_ENABLED : ST_SW_ON_DIS;
            end
            ST_FLT_REACT:  nxt_state = ST_FAULT;
            ST_FAULT: begin
                if (cmd == CMD_FAULT_RESET && !faultSrc) begin
                    nxt_state = ST_SW_ON_DIS;
                end
            end
            default:       nxt_state = ST_NOT_READY;
        endcase
        // a fault outranks any command outside the fault states
        if (faultSrc && state_ff != ST_FAULT && state_ff != ST_FLT_REACT) begin
            nxt_state = ST_FLT_REACT;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff <= ST_NOT_READY;
        end else if (clkEn) begin
            state_ff <= nxt_state;
        end
    end

    // (RQ17) latest code; a new fault wins over the clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            errCode_ff <= `ERR_NONE;
        end else if (clkEn) begin
            if (faultSrc) begin
                errCode_ff <= map_fault(faultSel, fwNewGen);
            // (RQ5) clear while bit 7 active
            end else if (cmd == CMD_FAULT_RESET) begin
                errCode_ff <= `ERR_NONE;
            end
        end
    end

    // (RQ5) warning latch and clear pulse
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            warn_ff       <= 1'b0;
            rstBit_ff     <= 1'b0;
            faultClear_ff <= 1'b0;
        end else if (clkEn) begin
            warn_ff       <= warnEvt || (warn_ff && cmd != CMD_FAULT_RESET);
            rstBit_ff     <= cmdWord_ff[`CW_FAULT_RESET];
            faultClear_ff <= cmdWord_ff[`CW_FAULT_RESET] && !rstBit_ff;
        end
    end

    // (RQ4) mode-specific bits per active mode
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            modeReq_ff <= '0;
        end else if (clkEn) begin
            modeReq_ff <= '0;
            // (RQ6) position sync mode sees none of them
            if (opMode != `MODE_CSP) begin
                modeReq_ff.haltReq <= cmdWord_ff[`CW_HALT];
            end
            if (opMode == `MODE_HM) begin
                modeReq_ff.homingStart <= cmdWord_ff[`CW_MODE_B4];
            end
            if (opMode == `MODE_PP) begin
                modeReq_ff.newSetPoint      <= cmdWord_ff[`CW_MODE_B4];
                modeReq_ff.changeNow        <= cmdWord_ff[`CW_MODE_B5];
                modeReq_ff.relativeMove     <= cmdWord_ff[`CW_MODE_B6];
                modeReq_ff.changeOnSetPoint <= cmdWord_ff[`CW_MODE_B9];
            end
        end
    end

    // (RQ18) status word tracks the state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stateWord_ff <= 16'h0000;
        end else if (clkEn) begin
            stateWord_ff <= encode_state(nxt_state, warnEvt || (warn_ff && cmd != CMD_FAULT_RESET));
        end
    end

    assign cmdWordRd  = cmdWord_ff;
    assign stateWord  = stateWord_ff;
    assign errCode    = errCode_ff;
    assign driveState = state_ff;
    assign modeReq    = modeReq_ff;
    assign faultClear = faultClear_ff;

    cmd_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ1
        clkEn && cmdWrEn |=> cmdWordRd == $past(cmdWrData))
        else $error("command word not stored");
    switch_on_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ8
        clkEn && !faultSrc && state_ff == ST_READY && cmdWord_ff[7:0] == 8'h07
        |=> driveState == ST_SWITCHED)
        else $error("switch-on not taken");
    dis_voltage_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ8
        clkEn && !faultSrc && !cmdWord_ff[7] && !cmdWord_ff[1]
        && state_ff inside {ST_READY, ST_SWITCHED, ST_OP_ENABLED}
        |=> driveState == ST_SW_ON_DIS)
        else $error("disable voltage not taken");
    quick_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ3
        (clkEn && !faultSrc && state_ff == ST_OP_ENABLED && cmdWord_ff[7:0] == 8'h0a)
        ##1 (clkEn && !faultSrc && cmdWord_ff[7:0] == 8'h0a)
        |=> driveState == ST_SW_ON_DIS && $past(driveState) == ST_QS_ACTIVE)
        else $error("quick stop lingered");
    enable_op_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ9
        clkEn && !faultSrc && state_ff == ST_SWITCHED && cmdWord_ff[7:0] == 8'h0f
        |=> driveState == ST_OP_ENABLED && stateWord[6:0] == 7'b0110111)
        else $error("enable operation failed");
    fault_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ10
        clkEn && !faultSrc && state_ff == ST_FAULT && cmdWord_ff[7]
        |=> driveState == ST_SW_ON_DIS && errCode == 16'h0000)
        else $error("fault reset not honoured");
    err_new_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ12
        clkEn && faultEvt && fwNewGen |=> errCode == {8'hff, $past(faultNum)})
        else $error("new error code wrong");
    err_sync_old_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ13
        clkEn && faultEvt && !fwNewGen && faultNum == 8'hcb |=> errCode == 16'hff93)
        else $error("old sync watchdog code wrong");
    err_torque_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ16
        clkEn && faultEvt && !fwNewGen && faultNum == 8'h6f |=> errCode == 16'h7121)
        else $error("old torque-off code wrong");
    csp_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
        clkEn && opMode == 8'h08 |=> modeReq == '0)
        else $error("position sync mode passed bits");
    pp_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ4
        clkEn && opMode == 8'h01 |=> modeReq.newSetPoint == $past(cmdWord_ff[4])
        && modeReq.changeOnSetPoint == $past(cmdWord_ff[9]))
        else $error("profile bits wrong");

endmodule : drive_control_word_decoder
`default_nettype wire

// *** design/drive_ctl_defines.svh ***
// offsets, field positions, error codes and mode numbers for the drive command decoder
// assumes inclusion by bare name from the package and the decoder module
// Functional notes
// (RQ1) 16-bit command word at 0x6040, written by the master, steers the state machine.
// (RQ2) command bits 0 to 3 together select state machine transitions.
// (RQ3) quick-stop bit only decodes; no distinct quick-stop deceleration exists.
// (RQ4) bits 4 to 6 follow mode: homing start, profile set-point bits with 9.
// (RQ5) command bit 7 active clears latched faults and warnings.
// (RQ6) cyclic synchronous position ignores bits 4 to 6, halt 8 and bit 9.
// (RQ7) master writes zero to bits 13 to 15; bits 10 to 12 reserved.
// (RQ8) shutdown 110, switch-on 111, disable-voltage bit1 zero, others ignored.
// (RQ9) quick-stop bit2 zero bit1 one; disable-op 0111; enable-op 1111.
// (RQ10) fault reset is bit 7 set regardless of others; don't-cares ignored.
// (RQ11) master writes unsupported mode-specific bits as zero; the model keeps halt bit 8 in position sync mode.
// (RQ12) newer firmware reports 0xff00 plus decimal fault number, e.g. 0xff29.
// (RQ13) sync watchdog fault reports 0xffcb new, 0xff93 first generation.
// (RQ14) process data map fault reports 0xffcc new, 0xff94 first generation.
// (RQ15) unsupported mode fault reports 0xffcd new, 0xff95 first generation.
// (RQ16) torque-off input fault reports 0xff6f new, 0x7121 first generation.
// (RQ17) read-only error code at 0x603f holds latest code; zero means none.
// (RQ18) status bits 0,1,2,3,5,6 encode the state, e.g. operation enabled.
// (RQ19) priority: fault reset, disable voltage, quick stop, then the rest.
`ifndef DRIVE_CTL_DEFINES_SVH
`define DRIVE_CTL_DEFINES_SVH

`define CMD_WORD_OFFSET      16'h6040
`define STATE_WORD_OFFSET    16'h6041
`define ERR_CODE_OFFSET      16'h603f

`define CW_SWITCH_ON         0
`define CW_ENABLE_VOLTAGE    1
`define CW_QUICK_STOP        2
`define CW_ENABLE_OP         3
`define CW_MODE_B4           4
`define CW_MODE_B5           5
`define CW_MODE_B6           6
`define CW_FAULT_RESET       7
`define CW_HALT              8
`define CW_MODE_B9           9

`define SW_VOLTAGE_EN        4
`define SW_WARNING           7
`define SW_REMOTE            9

`define CMD_WORD_RESET       16'h0000
`define ERR_NONE             16'h0000
`define ERR_NEW_BASE         8'hff
`define ERR_OLD_SYNC_OFS     8'h38
`define ERR_OLD_TORQUE_OFF   16'h7121

`define FLT_RESOLUTION       8'h29
`define FLT_TORQUE_OFF       8'h6f
`define FLT_SYNC_LOST        8'hc8
`define FLT_DC_LOCK          8'hca
`define FLT_SYNC_WATCHDOG    8'hcb
`define FLT_PD_MAP           8'hcc
`define FLT_BAD_MODE         8'hcd
`define FLT_COE_CFG          8'hce
`define FLT_FOE              8'hd0

`define MODE_PP              8'h01
`define MODE_PV              8'h03
`define MODE_TQ              8'h04
`define MODE_HM              8'h06
`define MODE_CSP             8'h08
`define MODE_CSV             8'h09
`define MODE_CST             8'h0a

`endif

// *** design/drive_ctl_pkg.sv ***
// types shared by the drive command decoder
// assumes the constants header is on the include path
`include "drive_ctl_defines.svh"

package drive_ctl_pkg;

    typedef enum logic [2:0] {
        ST_NOT_READY  = 3'b000,
        ST_SW_ON_DIS  = 3'b001,
        ST_READY      = 3'b010,
        ST_SWITCHED   = 3'b011,
        ST_OP_ENABLED = 3'b100,
        ST_QS_ACTIVE  = 3'b101,
        ST_FLT_REACT  = 3'b110,
        ST_FAULT      = 3'b111
    } state_t;

    typedef enum logic [2:0] {
        CMD_NONE        = 3'b000,
        CMD_SHUTDOWN    = 3'b001,
        CMD_SWITCH_ON   = 3'b010,
        CMD_DIS_VOLTAGE = 3'b011,
        CMD_QUICK_STOP  = 3'b100,
        CMD_DIS_OP      = 3'b101,
        CMD_ENABLE_OP   = 3'b110,
        CMD_FAULT_RESET = 3'b111
    } cmd_t;

    typedef struct packed {
        logic homingStart;
        logic newSetPoint;
        logic changeNow;
        logic relativeMove;
        logic changeOnSetPoint;
        logic haltReq;
    } mode_req_t;

endpackage : drive_ctl_pkg

// *** dv/drive_control_word_decoder_bench.sv ***
// self-checking bench for the drive command word decoder
// assumes the master model file and the design files are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.svh"

module drive_control_word_decoder_bench
    import drive_ctl_pkg::*;
;
    logic        sys_clk;
    logic        rst_b;
    logic        clkEn;
    logic        faultEvt;
    logic        warnEvt;
    logic        fwNewGen;
    logic [7:0]  opMode;
    logic [7:0]  faultNum;
    wire logic   cmdWrEn;
    wire logic [15:0] cmdWrData;
    logic [15:0] cmdWordRd;
    logic [15:0] stateWord;
    logic [15:0] errCode;
    state_t      driveState;
    mode_req_t   modeReq;
    logic        faultClear;
    int          miscompares;
    int          samples_checked;
    state_t      expSt;
    logic [15:0] w;
    logic [15:0] dTab [9] = '{16'h0006, 16'h0007, 16'h000f, 16'h0007, 16'h000f,
                              16'h000a, 16'h0006, 16'h0086, 16'h0000};
    logic [7:0]  mTab [4] = '{`MODE_HM, `MODE_PP, `MODE_CSP, `MODE_PV};
    logic [15:0] wTab [4] = '{16'h0010, 16'h0370, 16'h0370, 16'h0100};
    logic [5:0]  eTab [4] = '{6'h20, 6'h1f, 6'h00, 6'h01};
    logic [7:0]  fTab [9] = '{8'h29, 8'hcb, 8'hcb, 8'hcc, 8'hcc, 8'hcd, 8'hcd, 8'h6f, 8'h6f};
    logic        gTab [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    drive_master_model u_master (.sys_clk(sys_clk), .opMode(opMode), .cmdWrEn(cmdWrEn),
                                 .cmdWrData(cmdWrData));
    drive_control_word_decoder u_drive_control_word_decoder (.sys_clk(sys_clk),
        .rst_b(rst_b), .clkEn(clkEn), .cmdWrEn(cmdWrEn), .cmdWrData(cmdWrData),
        .opMode(opMode), .fwNewGen(fwNewGen), .faultEvt(faultEvt), .faultNum(faultNum),
        .warnEvt(warnEvt), .cmdWordRd(cmdWordRd), .stateWord(stateWord), .errCode(errCode),
        .driveState(driveState), .modeReq(modeReq), .faultClear(faultClear));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    function automatic logic [4:0] stBits(input state_t s);
        case (s)
            ST_SW_ON_DIS:  return 5'b10000;
            ST_READY:      return 5'b00001;
            ST_SWITCHED:   return 5'b00011;
            ST_OP_ENABLED: return 5'b00111;
            ST_QS_ACTIVE:  return 5'b00111;
            ST_FLT_REACT:  return 5'b01111;
            ST_FAULT:      return 5'b01000;
            default:       return 5'b00000;
        endcase
    endfunction : stBits

    task automatic chkState(input state_t s);
        check(16'(driveState), 16'(s), "drive state");
        check(16'({stateWord[6], stateWord[3:0]}), 16'(stBits(s)), "state bits");
    endtask : chkState

    // priority: fault reset, disable voltage, quick stop, shutdown, enable bit
    function automatic state_t nextSt(input state_t s, input logic [15:0] c);
        logic dv;
        logic qs;
        dv = !c[1];
        qs = !c[2];
        if (s == ST_QS_ACTIVE) return (c[3:0] == 4'hf && !c[7]) ? ST_OP_ENABLED : ST_SW_ON_DIS;
        if (c[7]) return (s == ST_FAULT) ? ST_SW_ON_DIS : s;
        case (s)
            ST_SW_ON_DIS:  return (!dv && !qs && !c[0]) ? ST_READY : s;
            ST_READY:      return (dv || qs) ? ST_SW_ON_DIS : (c[0] ? ST_SWITCHED : s);
            ST_SWITCHED:   return (dv || qs) ? ST_SW_ON_DIS :
                                  (!c[0] ? ST_READY : (c[3] ? ST_OP_ENABLED : s));
            ST_OP_ENABLED: return dv ? ST_SW_ON_DIS : qs ? ST_QS_ACTIVE :
                                  !c[0] ? ST_READY : !c[3] ? ST_SWITCHED : s;
            default:       return s;
        endcase
    endfunction : nextSt

    function automatic logic [15:0] codeExp(input logic [7:0] n, input logic g);
        if (!g && n == 8'h6f) return 16'h7121;
        if (!g && n >= 8'hc8 && n <= 8'hd0 && n != 8'hce) return {8'hff, n - 8'h38};
        return {8'hff, n};
    endfunction : codeExp

    task automatic clearFault();
        u_master.send(16'h0080);
        step(1);
        chkState(ST_SW_ON_DIS);
        check(errCode, 16'h0000, "error cleared");
        check(16'(faultClear), 16'h0001, "clear pulse");
        step(1);
        check(16'(stateWord[7]), 16'h0000, "warning cleared");
        check(16'(faultClear), 16'h0000, "clear pulse end");
        u_master.send(16'h0000);
        step(2);
    endtask : clearFault

    task automatic doFault(input logic [7:0] n, input logic g);
        @(posedge sys_clk);
        fwNewGen <= g;
        faultNum <= n;
        faultEvt <= 1'b1;
        warnEvt  <= 1'b1;
        @(posedge sys_clk);
        faultEvt <= 1'b0;
        warnEvt  <= 1'b0;
        faultNum <= ~n;
        #1;
        check(errCode, codeExp(n, g), "fault code");
        chkState(ST_FLT_REACT);
        step(1);
        chkState(ST_FAULT);
        check(16'(stateWord[7]), 16'h0001, "warning latched");
        clearFault();
    endtask : doFault

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #(20 * 20000);
        miscompares++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        clkEn = 1'b1;
        faultEvt = 1'b0;
        warnEvt = 1'b0;
        fwNewGen = 1'b1;
        opMode = `MODE_CSP;
        faultNum = 8'h00;
        miscompares = 0;
        samples_checked = 0;
        void'($urandom(3889));
        step(4);
        check(cmdWordRd, 16'h0000, "reset word");
        check(errCode, 16'h0000, "reset code");
        check(16'(driveState), 16'(ST_NOT_READY), "reset state");
        @(posedge sys_clk) rst_b <= 1'b1;
        step(2);
        chkState(ST_SW_ON_DIS);
        check(stateWord, 16'h0260, "state word after init");
        expSt = ST_SW_ON_DIS;
        // directed walk first, then random words checked against the model
        for (int i = 0; i < 160; i++) begin
            w = (i < 9) ? dTab[i] : 16'($urandom);
            u_master.send(w);
            step(1);
            check(cmdWordRd, w & 16'h1d8f, "word readback");
            expSt = nextSt(expSt, w);
            chkState(expSt);
            step(3);
            repeat (3) expSt = nextSt(expSt, w);
            chkState(expSt);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) opMode <= mTab[i];
            u_master.send(wTab[i]);
            step(2);
            check(16'(modeReq), 16'(eTab[i]), "mode bits");
        end
        u_master.send(16'h0000);
        step(2);
        for (int i = 0; i < 13; i++) begin
            if (i < 9) doFault(fTab[i], gTab[i]);
            else doFault(8'($urandom), 1'($urandom));
        end
        // the random faults leave the generation flag at a random value
        @(posedge sys_clk);
        fwNewGen <= 1'b1;
        opMode   <= 8'h02;
        repeat (4) if (errCode !== 16'hffcd) step(1);
        check(errCode, 16'hffcd, "mode fault code");
        step(2);
        chkState(ST_FAULT);
        @(posedge sys_clk) opMode <= `MODE_CSP;
        clearFault();
        // low enable drops the write and holds state
        @(posedge sys_clk) clkEn <= 1'b0;
        u_master.send(16'h0006);
        step(2);
        @(posedge sys_clk) clkEn <= 1'b1;
        step(2);
        check(cmdWordRd, 16'h0000, "frozen word");
        check(16'(driveState), 16'(ST_SW_ON_DIS), "frozen state");
        summarize();
    end
endmodule : drive_control_word_decoder_bench
`default_nettype wire

// *** dv/drive_master_model.sv ***
// fieldbus master model: writes command words into the decoder
// assumes the bench calls send() from a process synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_defines.svh"

module drive_master_model
    import drive_ctl_pkg::*;
(
    // clock and context
    input  wire logic        sys_clk,
    input  wire logic [7:0]  opMode,
    // command word write
    output logic             cmdWrEn,
    output logic [15:0]      cmdWrData
);
    initial begin
        cmdWrEn   = 1'b0;
        cmdWrData = 16'h0000;
    end

    task automatic send(input logic [15:0] w);
        logic [15:0] v;
        // mask after the edge so a mode change made at the previous edge is seen
        @(posedge sys_clk);
        v = w;
        v[15:13] = 3'h0;
        if (opMode != `MODE_PP) begin
            v[9]   = 1'b0;
            v[6:5] = 2'h0;
            if (opMode != `MODE_HM) begin
                v[4] = 1'b0;
            end
        end
        cmdWrEn   <= 1'b1;
        cmdWrData <= v;
        @(posedge sys_clk);
        cmdWrEn   <= 1'b0;
        // released data lines carry junk, never the last word
        cmdWrData <= ~v;
    endtask : send
endmodule : drive_master_model
`default_nettype wire
